// [gss_pkg.sv]
package gss_pkg;
	// bus geometry and gain set layout
	localparam int DW = 16;
	localparam int AW = 5;
	localparam int NGAIN = 7;
	localparam int NRAMP = 5;
	localparam int DIV_STEPS = 32;

	// gain index within a set
	localparam logic [2:0] G_SPD = 3'h0;
	localparam logic [2:0] G_INT = 3'h1;
	localparam logic [2:0] G_POS = 3'h2;
	localparam logic [2:0] G_TRQ = 3'h3;
	localparam logic [2:0] G_FRC = 3'h4;
	localparam logic [2:0] G_MFG = 3'h5;
	localparam logic [2:0] G_MFC = 3'h6;

	// register offsets (word index on the plain port)
	localparam logic [4:0] ADDR_SET1_BASE = 5'h00;
	localparam logic [4:0] ADDR_SET2_BASE = 5'h08;
	localparam logic [4:0] ADDR_MODE = 5'h10;
	localparam logic [4:0] ADDR_SPDCTL = 5'h11;
	localparam logic [4:0] ADDR_WAIT1 = 5'h12;
	localparam logic [4:0] ADDR_WAIT2 = 5'h13;
	localparam logic [4:0] ADDR_RAMP1 = 5'h14;
	localparam logic [4:0] ADDR_RAMP2 = 5'h15;
	localparam logic [4:0] ADDR_STATUS = 5'h16;

	// gain switch mode parameter digits
	localparam int METHOD_LSB = 0;
	localparam int COND_LSB = 4;
	localparam logic [3:0] METHOD_MANUAL = 4'h0;
	localparam logic [3:0] METHOD_AUTO = 4'h2;
	localparam logic [3:0] COND_INPOS_ON = 4'h0;
	localparam logic [3:0] COND_INPOS_OFF = 4'h1;
	localparam logic [3:0] COND_PROX_ON = 4'h2;
	localparam logic [3:0] COND_PROX_OFF = 4'h3;
	localparam logic [3:0] COND_REF_IDLE = 4'h4;
	localparam logic [3:0] COND_REF_IN = 4'h5;
	localparam logic [3:0] SPDCTL_PI = 4'h0;
	localparam logic [3:0] SPDCTL_IP = 4'h1;

	// reset values
	localparam logic [15:0] RST_SPD = 16'h0190;
	localparam logic [15:0] RST_INT = 16'h07D0;
	localparam logic [15:0] RST_POS = 16'h0190;
	localparam logic [15:0] RST_TRQ = 16'h0064;
	localparam logic [15:0] RST_FRC = 16'h0064;
	localparam logic [15:0] RST_MFG = 16'h01F4;
	localparam logic [15:0] RST_MFC = 16'h03E8;
	localparam logic [15:0] RST_MODE = 16'h0000;
	localparam logic [15:0] RST_SPDCTL = 16'h0000;
	localparam logic [15:0] RST_TIME = 16'h0000;

	// one millisecond step at the 40 ns control clock
	localparam int CLK_PERIOD_NS = 40;
	localparam int MS_TIME_NS = 1000000;
	localparam int MS_CYCLES = MS_TIME_NS / CLK_PERIOD_NS;

	localparam logic SET1 = 1'b0;
	localparam logic SET2 = 1'b1;

	typedef enum logic [1:0] {
		ST_STEADY = 2'b00,
		ST_WAIT = 2'b01,
		ST_RAMP = 2'b10
	} gss_state_t;

	// reset value of a gain slot, same for both sets
	function automatic logic [15:0] gss_gain_rst(input logic [2:0] idx);
		case (idx)
			G_SPD: gss_gain_rst = RST_SPD;
			G_INT: gss_gain_rst = RST_INT;
			G_POS: gss_gain_rst = RST_POS;
			G_TRQ: gss_gain_rst = RST_TRQ;
			G_FRC: gss_gain_rst = RST_FRC;
			G_MFG: gss_gain_rst = RST_MFG;
			default: gss_gain_rst = RST_MFC;
		endcase
	endfunction : gss_gain_rst
endpackage : gss_pkg

// [gss_switcher.sv]
// What this block does
// RULE1: mode digit 0 selects host-commanded switching (default), 2 selects automatic switching.
// RULE2: host never writes the reserved value 1 into the method digit.
// RULE3: each set holds speed, integral, position, torque filter, model-follow and friction gains.
// RULE4: automatic switching leaves both model-following values on their current set.
// RULE5: manual model-following switch only when idle and stopped; other gains switch anyway.
// RULE6: manual select bit 0 applies set 1, bit 1 applies set 2.
// RULE7: select bit comes from command I/O field, or option field in legacy profile.
// RULE8: condition A true moves to set 2 via wait/ramp 1; false returns via wait/ramp 2.
// RULE9: tens digit picks condition A in position control: codes 0 to 5.
// RULE10: outside position control even codes fix set 1, odd codes fix set 2.
// RULE11: on a condition change wait first, then ramp each gain linearly over switching time.
// RULE12: automatic switching only while speed loop runs PI or I-P control.
// RULE13: waiting and switching times are 0 to 65535 in 1 ms steps, default 0.
// RULE14: tuning-less function forces gain set 1 regardless of method.
// RULE15: counters run per control cycle; zero switching time applies new set next cycle. Here wait and ramp counts step once per 1 ms tick.
// RULE16: mode parameter changes act in the next control cycle without restart.
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module gss_switcher #(
	parameter int TICK_CYCLES = gss_pkg::MS_CYCLES
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic [gss_pkg::AW-1:0] reg_addr_i,
	input wire logic [gss_pkg::DW-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [gss_pkg::DW-1:0] reg_rdata_o,
	input wire logic legacy_profile_i,
	input wire logic servo_command_io_field_gsel_i,
	input wire logic option_field_gsel_i,
	input wire logic position_control_i,
	input wire logic positioning_complete_flag_i,
	input wire logic proximity_window_flag_i,
	input wire logic ref_filter_out_active_i,
	input wire logic ref_input_active_i,
	input wire logic cmd_executing_i,
	input wire logic motor_stopped_i,
	input wire logic tuning_less_i,
	output logic [gss_pkg::DW-1:0] speed_gain_o,
	output logic [gss_pkg::DW-1:0] speed_integral_o,
	output logic [gss_pkg::DW-1:0] position_gain_o,
	output logic [gss_pkg::DW-1:0] torque_filter_o,
	output logic [gss_pkg::DW-1:0] friction_gain_o,
	output logic [gss_pkg::DW-1:0] model_follow_gain_o,
	output logic [gss_pkg::DW-1:0] model_follow_comp_o,
	output logic [1:0] effective_set_o,
	output logic switching_o
);
	import gss_pkg::*;

	function automatic logic [15:0] gss_absdiff(input logic [15:0] a, input logic [15:0] b);
		gss_absdiff = (b >= a) ? (b - a) : (a - b);
	endfunction : gss_absdiff

	logic [15:0] gain_reg [0:1][0:NGAIN-1];
	logic [15:0] mode_reg;
	logic [15:0] spdctl_reg;
	logic [15:0] wait1_reg;
	logic [15:0] wait2_reg;
	logic [15:0] ramp1_reg;
	logic [15:0] ramp2_reg;
	logic [15:0] rdata_reg;
	logic [15:0] out_reg [0:NGAIN-1];
	logic [15:0] blend_reg [0:NRAMP-1];
	logic [1:0] eff_reg;
	logic sw_reg;
	gss_state_t state_reg;
	logic cur_reg;
	logic target_reg;
	logic mf_reg;
	logic [15:0] cnt_reg;
	logic [15:0] k_reg;
	logic [15:0] len_reg;
	logic ramp_init_reg;
	logic div_start_reg;
	logic [15:0] tick_cnt_reg;
	logic tick_reg;
	logic div_busy_reg;
	logic [2:0] div_idx_reg;
	logic [5:0] div_step_reg;
	logic [31:0] dvd_reg;
	logic [16:0] rem_reg;

	logic [3:0] method;
	logic [3:0] cond_code;
	logic auto_mode;
	logic auto_allowed;
	logic manual_sel;
	logic cond_a;
	logic desired;
	logic [16:0] rem_sh;
	logic div_ge;
	logic [16:0] rem_next;
	logic [31:0] dvd_next;
	logic [15:0] div_old;
	logic [15:0] div_new;

	// mode decode is combinational so a new value acts on the next edge
	assign method = mode_reg[METHOD_LSB +: 4]; // see RULE16
	assign cond_code = mode_reg[COND_LSB +: 4];
	assign auto_mode = (method == METHOD_AUTO); // see RULE1
	assign auto_allowed = (spdctl_reg[3:0] == SPDCTL_PI) || (spdctl_reg[3:0] == SPDCTL_IP); // see RULE12
	assign manual_sel = legacy_profile_i ? option_field_gsel_i : servo_command_io_field_gsel_i; // see RULE7

	// condition A selection; unlisted codes read as never true
	always_comb begin
		case (cond_code) // see RULE9
			COND_INPOS_ON: cond_a = positioning_complete_flag_i;
			COND_INPOS_OFF: cond_a = !positioning_complete_flag_i;
			COND_PROX_ON: cond_a = proximity_window_flag_i;
			COND_PROX_OFF: cond_a = !proximity_window_flag_i;
			COND_REF_IDLE: cond_a = !ref_filter_out_active_i && !ref_input_active_i;
			COND_REF_IN: cond_a = ref_input_active_i;
			default: cond_a = 1'b0;
		endcase
	end

	// outside position control the odd codes up to 5 pin set 2
	assign desired = position_control_i ? cond_a : (cond_code[0] && cond_code <= COND_REF_IN); // see RULE10

	// register writes; any method value other than 2 behaves as manual
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int s = 0; s < 2; s++) begin
				for (int i = 0; i < NGAIN; i++) begin
					gain_reg[s][i] <= gss_gain_rst(3'(i)); // see RULE3
				end
			end
			mode_reg <= RST_MODE;
			spdctl_reg <= RST_SPDCTL;
			wait1_reg <= RST_TIME; // see RULE13
			wait2_reg <= RST_TIME;
			ramp1_reg <= RST_TIME;
			ramp2_reg <= RST_TIME;
		end else if (reg_wr_i) begin
			if (reg_addr_i[4:3] == ADDR_SET1_BASE[4:3] && reg_addr_i[2:0] != 3'h7) begin
				gain_reg[0][reg_addr_i[2:0]] <= reg_wdata_i;
			end else if (reg_addr_i[4:3] == ADDR_SET2_BASE[4:3] && reg_addr_i[2:0] != 3'h7) begin
				gain_reg[1][reg_addr_i[2:0]] <= reg_wdata_i;
			end else begin
				case (reg_addr_i)
					ADDR_MODE: mode_reg <= reg_wdata_i;
					ADDR_SPDCTL: spdctl_reg <= reg_wdata_i;
					ADDR_WAIT1: wait1_reg <= reg_wdata_i;
					ADDR_WAIT2: wait2_reg <= reg_wdata_i;
					ADDR_RAMP1: ramp1_reg <= reg_wdata_i;
					ADDR_RAMP2: ramp2_reg <= reg_wdata_i;
					default: ;
				endcase
			end
		end
	end

	// read data valid only in the cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_reg <= 16'h0000;
		end else if (!reg_rd_i) begin
			rdata_reg <= 16'h0000;
		end else if (reg_addr_i[4] == 1'b0 && reg_addr_i[2:0] != 3'h7) begin
			rdata_reg <= gain_reg[reg_addr_i[3]][reg_addr_i[2:0]];
		end else begin
			case (reg_addr_i)
				ADDR_MODE: rdata_reg <= mode_reg;
				ADDR_SPDCTL: rdata_reg <= spdctl_reg;
				ADDR_WAIT1: rdata_reg <= wait1_reg;
				ADDR_WAIT2: rdata_reg <= wait2_reg;
				ADDR_RAMP1: rdata_reg <= ramp1_reg;
				ADDR_RAMP2: rdata_reg <= ramp2_reg;
				ADDR_STATUS: rdata_reg <= {11'h000, state_reg, mf_reg, eff_reg};
				default: rdata_reg <= 16'h0000;
			endcase
		end
	end

	// free-running millisecond enable; a first step may come early by under 1 ms
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tick_cnt_reg <= 16'h0000;
			tick_reg <= 1'b0;
		end else if (tick_cnt_reg == 16'(TICK_CYCLES - 1)) begin
			tick_cnt_reg <= 16'h0000;
			tick_reg <= 1'b1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 16'h0001;
			tick_reg <= 1'b0;
		end
	end

	// set selection: tuning-less first, then manual, then the automatic sequence
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_reg <= ST_STEADY;
			cur_reg <= SET1;
			target_reg <= SET1;
			mf_reg <= SET1;
			cnt_reg <= 16'h0000;
			k_reg <= 16'h0000;
			len_reg <= 16'h0000;
			ramp_init_reg <= 1'b0;
			div_start_reg <= 1'b0;
		end else begin
			ramp_init_reg <= 1'b0;
			div_start_reg <= 1'b0;
			if (tuning_less_i) begin
				state_reg <= ST_STEADY; // see RULE14
				cur_reg <= SET1;
				mf_reg <= SET1;
			end else if (!auto_mode) begin
				state_reg <= ST_STEADY;
				cur_reg <= manual_sel; // see RULE6
				if (!cmd_executing_i && motor_stopped_i) begin
					mf_reg <= manual_sel; // see RULE5
				end
			end else if (!auto_allowed) begin
				// other speed loop modes freeze the set that is in use
				state_reg <= ST_STEADY; // see RULE12
			end else begin
				// model-following set is left alone here
				case (state_reg) // see RULE4
					ST_STEADY: begin
						if (desired != cur_reg) begin
							target_reg <= desired; // see RULE8
							cnt_reg <= desired ? wait1_reg : wait2_reg;
							state_reg <= ST_WAIT;
						end
					end
					ST_WAIT: begin
						if (desired == cur_reg) begin
							state_reg <= ST_STEADY;
						end else if (cnt_reg == 16'h0000) begin
							len_reg <= target_reg ? ramp1_reg : ramp2_reg; // see RULE8
							if ((target_reg ? ramp1_reg : ramp2_reg) == 16'h0000) begin
								cur_reg <= target_reg; // see RULE15
								state_reg <= ST_STEADY;
							end else begin
								k_reg <= 16'h0000;
								ramp_init_reg <= 1'b1;
								state_reg <= ST_RAMP; // see RULE11
							end
						end else if (tick_reg) begin
							cnt_reg <= cnt_reg - 16'h0001; // see RULE11
						end
					end
					ST_RAMP: begin
						if (tick_reg) begin
							if (k_reg + 16'h0001 >= len_reg) begin
								cur_reg <= target_reg;
								state_reg <= ST_STEADY;
							end else begin
								k_reg <= k_reg + 16'h0001;
								div_start_reg <= 1'b1; // see RULE11
							end
						end
					end
					default: state_reg <= ST_STEADY;
				endcase
			end
		end
	end

	// one restoring-division step; quotient never exceeds the gain difference
	assign div_old = gain_reg[cur_reg][div_idx_reg];
	assign div_new = gain_reg[target_reg][div_idx_reg];
	assign rem_sh = {rem_reg[15:0], dvd_reg[31]};
	assign div_ge = rem_sh >= {1'b0, len_reg};
	assign rem_next = div_ge ? (rem_sh - {1'b0, len_reg}) : rem_sh;
	assign dvd_next = {dvd_reg[30:0], div_ge};

	// blended value old + (new - old) * k / len, one gain after the other
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int i = 0; i < NRAMP; i++) begin
				blend_reg[i] <= 16'h0000;
			end
			div_busy_reg <= 1'b0;
			div_idx_reg <= 3'h0;
			div_step_reg <= 6'h00;
			dvd_reg <= 32'h00000000;
			rem_reg <= 17'h00000;
		end else if (ramp_init_reg) begin
			for (int i = 0; i < NRAMP; i++) begin
				blend_reg[i] <= gain_reg[cur_reg][i];
			end
			div_busy_reg <= 1'b0;
		end else if (div_start_reg) begin
			div_busy_reg <= 1'b1;
			div_idx_reg <= 3'h0;
			div_step_reg <= 6'h00;
		end else if (div_busy_reg) begin
			if (div_step_reg == 6'h00) begin
				dvd_reg <= gss_absdiff(div_old, div_new) * k_reg; // see RULE11
				rem_reg <= 17'h00000;
				div_step_reg <= 6'h01;
			end else begin
				dvd_reg <= dvd_next;
				rem_reg <= rem_next;
				if (div_step_reg == 6'(DIV_STEPS)) begin
					blend_reg[div_idx_reg] <= (div_new >= div_old) ? (div_old + dvd_next[15:0])
						: (div_old - dvd_next[15:0]);
					div_step_reg <= 6'h00;
					if (div_idx_reg == 3'(NRAMP - 1)) begin
						div_busy_reg <= 1'b0;
					end else begin
						div_idx_reg <= div_idx_reg + 3'h1;
					end
				end else begin
					div_step_reg <= div_step_reg + 6'h01;
				end
			end
		end
	end

	// registered gain outputs; blend is only loaded one cycle into the ramp, so hold the old set until then
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int i = 0; i < NGAIN; i++) begin
				out_reg[i] <= gss_gain_rst(3'(i));
			end
			eff_reg <= 2'h1;
			sw_reg <= 1'b0;
		end else begin
			for (int i = 0; i < NRAMP; i++) begin
				out_reg[i] <= (state_reg == ST_RAMP && !ramp_init_reg) ? blend_reg[i] : gain_reg[cur_reg][i]; // see RULE3
			end
			out_reg[G_MFG] <= gain_reg[mf_reg][G_MFG];
			out_reg[G_MFC] <= gain_reg[mf_reg][G_MFC];
			eff_reg <= cur_reg ? 2'h2 : 2'h1;
			sw_reg <= (state_reg != ST_STEADY);
		end
	end

	assign reg_rdata_o = rdata_reg;
	assign speed_gain_o = out_reg[G_SPD];
	assign speed_integral_o = out_reg[G_INT];
	assign position_gain_o = out_reg[G_POS];
	assign torque_filter_o = out_reg[G_TRQ];
	assign friction_gain_o = out_reg[G_FRC];
	assign model_follow_gain_o = out_reg[G_MFG];
	assign model_follow_comp_o = out_reg[G_MFC];
	assign effective_set_o = eff_reg;
	assign switching_o = sw_reg;
endmodule : gss_switcher

// [gss_switcher_monitor.sv]
`timescale 1ns/1ps
module gss_switcher_monitor (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic [gss_pkg::AW-1:0] reg_addr_i,
	input wire logic [gss_pkg::DW-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic legacy_profile_i,
	input wire logic servo_command_io_field_gsel_i,
	input wire logic option_field_gsel_i,
	input wire logic position_control_i,
	input wire logic positioning_complete_flag_i,
	input wire logic tuning_less_i,
	input wire logic [gss_pkg::DW-1:0] model_follow_gain_o,
	input wire logic [gss_pkg::DW-1:0] model_follow_comp_o,
	input wire logic [1:0] effective_set_o,
	input wire logic switching_o
);
	import gss_pkg::*;
	logic [15:0] mode_reg, spd_reg;
	logic [3:0] tz_reg;
	logic sel, auto, manual, zcfg;
	// shadow of the mode words, the checker cannot see the real ones
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mode_reg <= RST_MODE;
			spd_reg <= RST_SPDCTL;
		end else if (reg_wr_i && reg_addr_i == ADDR_MODE) begin
			mode_reg <= reg_wdata_i;
		end else if (reg_wr_i && reg_addr_i == ADDR_SPDCTL) begin
			spd_reg <= reg_wdata_i;
		end
	end
	// one flag per wait or ramp word, high while that word is zero
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tz_reg <= 4'hF;
		end else if (reg_wr_i && reg_addr_i >= ADDR_WAIT1 && reg_addr_i <= ADDR_RAMP2) begin
			tz_reg[reg_addr_i[1:0] - 2'h2] <= reg_wdata_i == 16'h0000;
		end
	end
	// zero times only, so every auto change must land within a few cycles
	assign sel = legacy_profile_i ? option_field_gsel_i : servo_command_io_field_gsel_i;
	assign auto = mode_reg[3:0] == METHOD_AUTO;
	assign manual = !auto && !tuning_less_i;
	assign zcfg = auto && !tuning_less_i && spd_reg[3:0] <= SPDCTL_IP && tz_reg == 4'hF;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	a_eff_set_legal: assert property (effective_set_o == 2'h1 || effective_set_o == 2'h2)
		else $error("effective set out of range");
	a_manual_follows_sel: assert property (
		(manual && $stable(sel)) [*3] |-> effective_set_o == {1'b0, sel} + 2'h1)
		else $error("manual set does not follow select bit");
	a_manual_no_switch: assert property (manual [*3] |-> !switching_o)
		else $error("switching flag raised in manual mode");
	a_tl_forces_set1: assert property (tuning_less_i [*3] |-> effective_set_o == 2'h1)
		else $error("tuning-less did not force set 1");
	a_auto_mf_stable: assert property (
		(auto && !tuning_less_i && !reg_wr_i) [*4]
		|-> $stable(model_follow_gain_o) && $stable(model_follow_comp_o))
		else $error("model-following value moved in auto mode");
	a_spd_blocks_auto: assert property ((auto && spd_reg[3:0] > SPDCTL_IP) [*3] |-> !switching_o)
		else $error("auto switching ran outside PI or I-P");
	a_zero_time_apply: assert property (
		(zcfg && position_control_i && mode_reg[7:4] == COND_INPOS_ON && $stable(positioning_complete_flag_i)) [*6]
		|-> effective_set_o == {1'b0, positioning_complete_flag_i} + 2'h1)
		else $error("zero-time switch not applied");
	a_fixed_outside_pos: assert property (
		(zcfg && !position_control_i && mode_reg[7:4] <= COND_REF_IN) [*6]
		|-> effective_set_o == {1'b0, mode_reg[4]} + 2'h1)
		else $error("fixed set wrong outside position control");
endmodule : gss_switcher_monitor
bind gss_switcher gss_switcher_monitor gss_switcher_monitor_inst (.*);

// [gss_host_model.sv]
`timescale 1ns/1ps
module gss_host_model (
	input wire logic legacy_i,
	input wire logic req_i,
	output logic io_gsel_o,
	output logic opt_gsel_o
);
	// unused field carries the inverse, so a wrong field pick shows
	assign io_gsel_o = legacy_i ? !req_i : req_i;
	assign opt_gsel_o = legacy_i ? req_i : !req_i;
endmodule : gss_host_model

// [gss_switcher_tb_top.sv]
`timescale 1ns/1ps
module gss_switcher_tb_top;
	import gss_pkg::*;
	logic clk_i = 0, arst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, io_g, opt_g, sw;
	logic legacy = 0, pctl = 1, inpos = 0, prox = 0, rfo = 0, rin = 0, cmd = 0, stop = 1, tl = 0, req = 0;
	logic [4:0] reg_addr_i = 5'h00;
	logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o, spd, itg, pos, trq, frc, mfg, mfc;
	logic [15:0] e1 [7], e2 [7], g [7];
	logic [3:0] ct [6] = '{4'h8, 4'h0, 4'h4, 4'h0, 4'h0, 4'h1};
	logic [3:0] cf [6] = '{4'h0, 4'h8, 4'h0, 4'h4, 4'h2, 4'h0};
	logic [1:0] eff;
	logic mid;
	int fail_count = 0, cmp_count = 0, n;
	always_comb g = '{spd, itg, pos, trq, frc, mfg, mfc};
	gss_host_model gss_host_model_inst (.legacy_i(legacy), .req_i(req), .io_gsel_o(io_g), .opt_gsel_o(opt_g));
	gss_switcher #(.TICK_CYCLES(200)) gss_switcher_inst (.clk_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
		.reg_rd_i, .reg_rdata_o, .legacy_profile_i(legacy), .servo_command_io_field_gsel_i(io_g),
		.option_field_gsel_i(opt_g), .position_control_i(pctl), .positioning_complete_flag_i(inpos),
		.proximity_window_flag_i(prox), .ref_filter_out_active_i(rfo), .ref_input_active_i(rin),
		.cmd_executing_i(cmd), .motor_stopped_i(stop), .tuning_less_i(tl), .speed_gain_o(spd),
		.speed_integral_o(itg), .position_gain_o(pos), .torque_filter_o(trq), .friction_gain_o(frc),
		.model_follow_gain_o(mfg), .model_follow_comp_o(mfc), .effective_set_o(eff), .switching_o(sw));
	// 25 MHz control clock
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	// data stands only in the cycle after the strobe
	task automatic rd(input logic [4:0] a, input logic [15:0] exp);
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1 chk(reg_rdata_o, exp);
	endtask : rd
	task automatic cond(input logic p, input logic [3:0] v);
		@(posedge clk_i);
		{pctl, inpos, prox, rfo, rin} <= {p, v};
	endtask : cond
	// five ramped gains follow s, the model-following pair follows m
	task automatic chk_out(input logic [1:0] s, input logic [1:0] m);
		@(negedge clk_i);
		chk({14'h0000, eff}, {14'h0000, s});
		for (int i = 0; i < 7; i++) chk(g[i], (i < 5 ? s : m) == 2'h2 ? e2[i] : e1[i]);
		// hand back on a rising edge so the next stimulus lands there
		@(posedge clk_i);
	endtask : chk_out
	// bounded wait for the effective set, noting any in-between position gain
	task automatic wait_set(input logic [1:0] s, input int lim);
		n = 0;
		mid = 0;
		// a change applied just now has not reached the set output yet
		repeat (4) @(posedge clk_i);
		while (eff !== s) begin
			@(negedge clk_i);
			n++;
			if (pos !== e1[2] && pos !== e2[2]) mid = 1;
			if (n > lim) begin
				chk({14'h0000, eff}, {14'h0000, s});
				finish_test();
			end
		end
		repeat (2) @(posedge clk_i);
	endtask : wait_set
	initial begin
		e1 = '{RST_SPD, RST_INT, RST_POS, RST_TRQ, RST_FRC, RST_MFG, RST_MFC};
		for (int i = 0; i < 7; i++) e2[i] = 16'h0A00 + 16'(i);
		repeat (10) @(posedge clk_i);
		arst_n_i <= 1'b1;
		for (int i = 0; i < 7; i++) rd(5'(i), e1[i]);
		rd(ADDR_MODE, RST_MODE);
		rd(ADDR_WAIT1, RST_TIME);
		rd(5'h07, 16'h0000);
		rd(5'h1F, 16'h0000);
		chk_out(2'h1, 2'h1);
		for (int i = 0; i < 7; i++) wr(ADDR_SET2_BASE + 5'(i), e2[i]);
		wr(5'h0F, 16'hFFFF);
		rd(5'h0F, 16'h0000);
		wr(ADDR_WAIT2, 16'hFFFF);
		rd(ADDR_WAIT2, 16'hFFFF);
		wr(ADDR_WAIT2, 16'h0000);
		// manual switching through the host command fields
		req <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk_out(2'h2, 2'h2);
		legacy <= 1'b1;
		req <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk_out(2'h1, 2'h1);
		cmd <= 1'b1;
		req <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk_out(2'h2, 2'h1);
		cmd <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk_out(2'h2, 2'h2);
		tl <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk_out(2'h1, 2'h1);
		tl <= 1'b0;
		req <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk_out(2'h1, 2'h1);
		// every condition code, reserved method value never written
		for (int c = 0; c < 6; c++) begin
			cond(1'b1, cf[c]);
			wr(ADDR_MODE, {8'h00, 4'(c), METHOD_AUTO});
			wait_set(2'h1, 20);
			chk_out(2'h1, 2'h1);
			cond(1'b1, ct[c]);
			wait_set(2'h2, 20);
			chk_out(2'h2, 2'h1);
			cond(1'b0, cf[c]);
			wait_set(c[0] ? 2'h2 : 2'h1, 20);
			chk_out(c[0] ? 2'h2 : 2'h1, 2'h1);
		end
		// speed loop mode outside PI and I-P blocks the switch
		cond(1'b1, 4'h0);
		wr(ADDR_MODE, {8'h00, COND_INPOS_ON, METHOD_AUTO});
		wr(ADDR_SPDCTL, 16'h0002);
		cond(1'b1, 4'h8);
		repeat (10) @(posedge clk_i);
		@(negedge clk_i);
		chk({15'h0000, sw}, 16'h0000);
		chk_out(2'h1, 2'h1);
		wr(ADDR_SPDCTL, {12'h000, SPDCTL_IP});
		wait_set(2'h2, 20);
		chk_out(2'h2, 2'h1);
		// waiting time then a linear ramp, ticks of 200 cycles
		cond(1'b1, 4'h0);
		wait_set(2'h1, 20);
		wr(ADDR_WAIT1, 16'h0003);
		wr(ADDR_RAMP1, 16'h0004);
		cond(1'b1, 4'h8);
		repeat (20) @(negedge clk_i);
		chk({15'h0000, sw}, 16'h0001);
		wait_set(2'h2, 2000);
		chk(16'(n >= 900 && n <= 1800), 16'h0001);
		chk({15'h0000, mid}, 16'h0001);
		chk_out(2'h2, 2'h1);
		finish_test();
	end
endmodule : gss_switcher_tb_top
